// *** rtl/sbsp_pkg.sv ***
// shared constants for the synchronous burst sram port
package sbsp_pkg;
    localparam int LANES = 4;
    localparam int LANE_BITS = 9;
    localparam int DATA_BITS = LANES * LANE_BITS;
    localparam int ADDR_BITS = 19;
    localparam int BURST_BITS = 2;
    localparam int MEM_WORDS = 1024;
    localparam int MEM_ABITS = 10;
    localparam logic [BURST_BITS-1:0] BURST_ONE = 2'h1;
    localparam logic [BURST_BITS-1:0] BURST_ZERO = 2'h0;
    localparam logic [ADDR_BITS-1:0] ADDR_ZERO = 19'h00000;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hf;
    localparam logic [DATA_BITS-1:0] DATA_ZERO = 36'h000000000;
    typedef enum logic [0:0] {
        SBSP_IDLE = 1'b0,
        SBSP_BURST = 1'b1
    } sbsp_state_t;
endpackage

// *** rtl/sbsp_port.sv ***
// synchronous burst sram port: address capture, burst counter, writes
// Function
// - all synchronous inputs registered only on rising clock edge
// - address loads when a strobe is low and all selects active
// - two low address bits set the burst start; a load clears the 2-bit counter
// - burst counter steps on each non-load edge of a burst with advance sampled low
// - lane write select works only when qualified by byte-write enable
// - controller drives byte-write enable low for byte writes
// - global write low writes all lanes, ignoring lane selects
// - each lane is eight data bits plus one parity bit
// - processor strobe wins over controller; ignored if first select high
// - burst order strap: low linear, high interleaved, kept static
// - selected only with first and third low and second high
module sbsp_port
    import sbsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [sbsp_pkg::ADDR_BITS-1:0] addr_i,
    input wire logic processor_address_strobe_n_i,
    input wire logic controller_address_strobe_n_i,
    input wire logic burst_advance_n_i,
    input wire logic chip_select_first_n_i,
    input wire logic chip_select_second_i,
    input wire logic chip_select_third_n_i,
    input wire logic [sbsp_pkg::LANES-1:0] lane_write_select_n_i,
    input wire logic byte_write_qualify_n_i,
    input wire logic all_lanes_write_n_i,
    input wire logic burst_order_i,
    input wire logic [sbsp_pkg::DATA_BITS-1:0] data_i,
    output logic [sbsp_pkg::DATA_BITS-1:0] data_o,
    output logic [sbsp_pkg::DATA_BITS-1:0] data_oe_n_o,
    output logic [sbsp_pkg::ADDR_BITS-1:0] cur_addr_o,
    output logic [sbsp_pkg::LANES-1:0] lanes_written_o
);
    import sbsp_pkg::*;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function automatic logic selected(input logic c1n, input logic c2,
                                      input logic c3n);
        selected = !c1n && c2 && !c3n;
    endfunction

    function automatic logic [BURST_BITS-1:0] burst_low(
        input logic [BURST_BITS-1:0] start,
        input logic [BURST_BITS-1:0] cnt,
        input logic interleaved);
        if (interleaved)
        begin
            burst_low = start ^ cnt;
        end
        else
        begin
            burst_low = start + cnt;
        end
    endfunction

    // ---------------------------------------------------------------
    // address and burst state
    // ---------------------------------------------------------------
    sbsp_state_t state;
    sbsp_state_t next_state;
    logic [ADDR_BITS-1:0] base_addr;
    logic [ADDR_BITS-1:0] next_base_addr;
    logic [BURST_BITS-1:0] burst_cnt;
    logic [BURST_BITS-1:0] next_burst_cnt;
    logic load_p;
    logic load_c;
    logic load;
    logic [ADDR_BITS-1:0] eff_addr;

    always_comb
    begin
        // processor strobe wins, and needs first select low
        load_p = !processor_address_strobe_n_i
                 && !chip_select_first_n_i;
        load_c = processor_address_strobe_n_i
                 && !controller_address_strobe_n_i;
        load = (load_p || load_c)
               && selected(chip_select_first_n_i, chip_select_second_i,
                           chip_select_third_n_i);
        next_state = state;
        next_base_addr = base_addr;
        next_burst_cnt = burst_cnt;
        if (load)
        begin
            next_state = SBSP_BURST;
            next_base_addr = addr_i;
            next_burst_cnt = BURST_ZERO;
        end
        else if (state == SBSP_BURST && !burst_advance_n_i)
        begin
            next_burst_cnt = burst_cnt + BURST_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= SBSP_IDLE;
            base_addr <= ADDR_ZERO;
            burst_cnt <= BURST_ZERO;
        end
        else
        begin
            state <= next_state;
            base_addr <= next_base_addr;
            burst_cnt <= next_burst_cnt;
        end
    end

    // address of the beat taken at this edge: a load starts at addr_i
    always_comb
    begin
        eff_addr = {next_base_addr[ADDR_BITS-1:BURST_BITS],
                    burst_low(next_base_addr[BURST_BITS-1:0],
                              next_burst_cnt, burst_order_i)};
    end

    // ---------------------------------------------------------------
    // write qualification and storage
    // ---------------------------------------------------------------
    logic [LANES-1:0] lane_we;
    logic [LANES-1:0] next_lanes_written;
    wire logic [DATA_BITS-1:0] rd_word;
    logic [MEM_ABITS-1:0] mem_idx;

    always_comb
    begin
        if (!all_lanes_write_n_i)
        begin
            lane_we = LANES_ALL;
        end
        else if (!byte_write_qualify_n_i)
        begin
            lane_we = ~lane_write_select_n_i;
        end
        else
        begin
            lane_we = LANES_NONE;
        end
        if (state != SBSP_BURST && !load)
        begin
            lane_we = LANES_NONE;
        end
        next_lanes_written = lane_we;
        mem_idx = eff_addr[MEM_ABITS-1:0];
    end

    // each lane holds eight data bits and its parity bit
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            // one array per lane so each has a single writer
            logic [LANE_BITS-1:0] lane_mem [MEM_WORDS];
            always_ff @(posedge clk_i)
            begin
                if (lane_we[g])
                begin
                    lane_mem[mem_idx] <=
                        data_i[g*LANE_BITS +: LANE_BITS];
                end
            end
            assign rd_word[g*LANE_BITS +: LANE_BITS] = lane_mem[mem_idx];
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_o <= DATA_ZERO;
            data_oe_n_o <= {DATA_BITS{1'b1}};
            cur_addr_o <= ADDR_ZERO;
            lanes_written_o <= LANES_NONE;
        end
        else
        begin
            data_o <= rd_word;
            data_oe_n_o <= {DATA_BITS{1'b1}};
            cur_addr_o <= eff_addr;
            lanes_written_o <= next_lanes_written;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_load;
        @(posedge clk_i) disable iff (!rst_n_i)
        load |=> (cur_addr_o == $past(addr_i));
    endproperty
    a_load: assert property (p_load)
        else $error("address not loaded");

    property p_sel;
        @(posedge clk_i) disable iff (!rst_n_i)
        chip_select_second_i == 1'b0 |-> !load;
    endproperty
    a_sel: assert property (p_sel)
        else $error("load while deselected");

    property p_adv;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state == SBSP_BURST && !load && !burst_advance_n_i)
        |=> burst_cnt == $past(burst_cnt) + BURST_ONE;
    endproperty
    a_adv: assert property (p_adv)
        else $error("burst did not step");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!load && burst_advance_n_i) |=> $stable(burst_cnt);
    endproperty
    a_hold: assert property (p_hold) else $error("burst stepped");

    property p_gw;
        @(posedge clk_i) disable iff (!rst_n_i)
        (load && !all_lanes_write_n_i) |=> lanes_written_o == LANES_ALL;
    endproperty
    a_gw: assert property (p_gw) else $error("global write lost");

    property p_bwe;
        @(posedge clk_i) disable iff (!rst_n_i)
        (all_lanes_write_n_i && byte_write_qualify_n_i)
        |=> lanes_written_o == LANES_NONE;
    endproperty
    a_bwe: assert property (p_bwe) else $error("unqualified write");

    property p_lane;
        @(posedge clk_i) disable iff (!rst_n_i)
        (load && all_lanes_write_n_i && !byte_write_qualify_n_i)
        |=> lanes_written_o == ~$past(lane_write_select_n_i);
    endproperty
    a_lane: assert property (p_lane) else $error("lane mismatch");

    property p_prio;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!processor_address_strobe_n_i && chip_select_first_n_i) |-> !load;
    endproperty
    a_prio: assert property (p_prio)
        else $error("strobe not ignored");
endmodule

// *** testbench/sbsp_host.sv ***
// bus master model driving the sram port after each falling edge
module sbsp_host
    import sbsp_pkg::*;
(
    input wire logic clk_i,
    output logic [sbsp_pkg::ADDR_BITS-1:0] addr_o,
    output logic [7:0] ctl_o,
    output logic [sbsp_pkg::LANES-1:0] sel_n_o,
    output logic [sbsp_pkg::DATA_BITS-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        addr_o = ADDR_ZERO;
        ctl_o = 8'hff;
        sel_n_o = LANES_ALL;
        data_o = DATA_ZERO;
    end
    // ctl: strobe_p, strobe_c, adv, cs1, cs2, cs3, qualify, global (all _n except cs2, active high)
    task automatic cycle(input logic [ADDR_BITS-1:0] a,
        input logic [7:0] c, input logic [LANES-1:0] s);
        @(negedge clk_i);
        addr_o = a;
        ctl_o = c;
        sel_n_o = s;
        data_o = DATA_BITS'({$urandom(), $urandom()});
    endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the burst sram port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbsp_pkg::*;
    localparam int DAT_LO = ADDR_BITS + LANES + 1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic order = 1'b0;
    logic burst = 1'b0;
    logic [1:0] cnt = 2'h0;
    logic [ADDR_BITS-1:0] base = ADDR_ZERO;
    logic [ADDR_BITS-1:0] addr, cur_addr;
    logic [7:0] ctl;
    logic [LANES-1:0] sel_n, lanes;
    logic [DATA_BITS-1:0] wdata, rdata;
    logic [DATA_BITS-1:0] shadow [MEM_WORDS];
    logic [DATA_BITS+ADDR_BITS+LANES:0] notes[$];
    logic [DATA_BITS+ADDR_BITS+LANES:0] note;
    int failures = 0;
    int tests_run = 0;
    initial forever #12.5 clk = ~clk;
    sbsp_host i_host (.clk_i(clk), .addr_o(addr), .ctl_o(ctl),
        .sel_n_o(sel_n), .data_o(wdata));
    sbsp_port i_dut (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
        .processor_address_strobe_n_i(ctl[7]),
        .controller_address_strobe_n_i(ctl[6]),
        .burst_advance_n_i(ctl[5]), .chip_select_first_n_i(ctl[4]),
        .chip_select_second_i(ctl[3]), .chip_select_third_n_i(ctl[2]),
        .lane_write_select_n_i(sel_n), .byte_write_qualify_n_i(ctl[1]),
        .all_lanes_write_n_i(ctl[0]), .burst_order_i(order),
        .data_i(wdata), .data_o(rdata), .data_oe_n_o(),
        .cur_addr_o(cur_addr), .lanes_written_o(lanes));
    task automatic conclude();
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp_addr(input logic [ADDR_BITS-1:0] e, a);
        tests_run++;
        if (a !== e)
        begin
            failures++;
            $display("[ERR] cur_addr_o expected %h seen %h", e, a);
        end
    endtask
    task automatic cmp_lanes(input logic [LANES-1:0] e, a);
        tests_run++;
        if (a !== e)
        begin
            failures++;
            $display("[ERR] lanes_written_o expected %h seen %h", e, a);
        end
    endtask
    task automatic cmp_data(input logic [DATA_BITS-1:0] e, a);
        tests_run++;
        if (a !== e)
        begin
            failures++;
            $display("[ERR] data_o expected %h seen %h", e, a);
        end
    endtask
    task automatic step(input logic [ADDR_BITS-1:0] a, input logic [7:0] c,
        input logic [LANES-1:0] s);
        logic [LANES-1:0] wr;
        logic [1:0] low;
        logic [MEM_ABITS-1:0] idx;
        logic [DATA_BITS-1:0] rd;
        wr = !c[0] ? LANES_ALL : (!c[1] ? ~s : LANES_NONE);
        if (!c[4] && c[3] && !c[2] && (!c[7] || !c[6]))
        begin
            base = a;
            cnt = BURST_ZERO;
            burst = 1'b1;
        end
        else if (burst && !c[5])
            cnt = cnt + BURST_ONE;
        low = order ? base[1:0] ^ cnt : base[1:0] + cnt;
        idx = {base[MEM_ABITS-1:2], low};
        rd = shadow[idx];
        i_host.cycle(a, c, s);
        for (int g = 0; g < LANES; g++)
            if (burst && wr[g])
                shadow[idx][g*LANE_BITS +: LANE_BITS] =
                    i_host.data_o[g*LANE_BITS +: LANE_BITS];
        notes.push_back({rd, burst, base[ADDR_BITS-1:2], low,
            burst ? wr : LANES_NONE});
    endtask
    task automatic restart(input logic o);
        @(negedge clk);
        rst_n = 1'b0;
        order = o;
        burst = 1'b0;
        base = ADDR_ZERO;
        cnt = BURST_ZERO;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
    endtask
    always
    begin
        @(posedge clk);
        #1;
        if (notes.size() > 0)
        begin
            note = notes.pop_front();
            cmp_lanes(note[LANES-1:0], lanes);
            cmp_data(DATA_BITS'(note >> DAT_LO), rdata);
            if (note[ADDR_BITS+LANES])
                cmp_addr(note[ADDR_BITS+LANES-1:LANES], cur_addr);
        end
    end
    initial
    begin
        repeat (1000) @(posedge clk);
        failures++;
        conclude();
    end
    initial
    begin
        logic [7:0] c;
        void'($urandom(14959));
        for (int o = 0; o < 2; o++)
        begin
            restart(o[0]);
            for (int k = 0; k < 8; k++)
                if (k != 2)
                    step(ADDR_BITS'($urandom()), {3'h1, k[2:0], 2'h2},
                        LANES_NONE);
            for (int i = 0; i < 60; i++)
            begin
                c = 8'($urandom());
                c[7] = ($urandom() % 4) != 0;
                c[6] = ($urandom() % 4) != 0;
                c[4:2] = 3'b010;
                step(ADDR_BITS'($urandom()), c, LANES'($urandom()));
            end
            step(ADDR_BITS'($urandom()) | 19'h00003, 8'h6b, LANES_ALL);
            repeat (5) step(ADDR_ZERO, 8'hcb, LANES_ALL);
            step(ADDR_ZERO, 8'heb, LANES_ALL);
        end
        repeat (2) @(negedge clk);
        conclude();
    end
endmodule
